// [deep_standby_power_control_tb.sv]
// self-checking bench for the deep standby power controller
`timescale 1ns/10ps
module deep_standby_power_control_tb;
  import dsbpc_pkg::*;
  localparam int REG_CYC = 20;
  localparam int OSC_CYC = 10;
  logic clk, reset, hsel, hwrite, hreadyout, hresp, sys_reset, hready;
  logic [31:0] haddr, hwdata, hrdata, rd_v, rnd, ctl;
  logic [1:0] htrans;
  logic [2:0] hsize, sel;
  logic [3:0] other_reset_req, st;
  logic [4:0] port0_pfr_keep;
  logic sub_osc_ready_flag, cpu_deep_sleep_bit, cpu_sleep_req, fire;
  logic external_reset_pin_n, wake_up_pin, lv_reset, lv_irq, rtc_irq, rcv_irq;
  logic hcr_run_force, pins_hiz, pins_gpio, rtc, lvl, woke;
  dsbpc_clk_t clk_en;
  dsbpc_pwr_t pwr_on;
  dsbpc_rst_t dstb_rst;
  int errors, n_checks, cyc, c;
  int seed = 4210;
  assign hready = hreadyout;
  assign st = {pwr_on.cpu, pwr_on.sram, pins_hiz, clk_en.sub_en};
  dsbpc_ctrl #(.REG_CYC(REG_CYC), .OSC_CYC(OSC_CYC)) uut (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .sub_osc_ready_flag, .cpu_deep_sleep_bit,
    .cpu_sleep_req, .external_reset_pin_n, .wake_up_pin, .lv_reset, .lv_irq,
    .rtc_irq, .rcv_irq, .other_reset_req, .sys_reset, .clk_en, .pwr_on,
    .dstb_rst, .port0_pfr_keep, .hcr_run_force, .pins_hiz, .pins_gpio
  );
  dsbpc_wake_model u_wake (
    .clk, .fire, .sel, .external_reset_pin_n, .wake_up_pin, .lv_reset,
    .lv_irq, .rtc_irq, .rcv_irq
  );
  function automatic logic wakes(input logic in_rtc, input int cause);
    return in_rtc || (cause != 1 && cause != 2);
  endfunction
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL time %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(rd_v, exp);
  endtask
  task automatic wait_run();
    for (int k = 0; k < 80 && clk_en.cpu_en !== 1'b1; k++)
      @(posedge clk);
  endtask
  task automatic enter();
    bus(RTC_MODE_CTRL_OFS, 1'b1, {31'h0, rtc});
    bus(WAKE_CAUSE_OFS, 1'b1, 32'h3F);
    ctl = {STANDBY_KEY, 11'h0, lvl, 2'h1, STYPE_STOP};
    bus(STANDBY_CTRL_OFS, 1'b1, ctl);
    // no flash algorithm ever runs here, so entry may follow
    @(posedge clk);
    cpu_deep_sleep_bit <= 1'b1;
    @(posedge clk);
    cpu_sleep_req <= 1'b1;
    @(posedge clk);
    {cpu_sleep_req, cpu_deep_sleep_bit} <= 2'h0;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      errors++;
      test_done();
    end
  end
  initial begin
    {reset, hsel, hwrite, cpu_deep_sleep_bit, cpu_sleep_req, fire} = 6'h20;
    {haddr, hwdata, htrans, hsize, sel, other_reset_req} = '0;
    sub_osc_ready_flag = 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // keep mask loads at the first edge after release, seen at the second
    repeat (2) @(posedge clk);
    chk(32'({hresp, pwr_on, clk_en, dstb_rst}), 32'hFFFF0);
    chk(32'(port0_pfr_keep), 32'h1F);
    rnd = $random(seed);
    bus(STANDBY_CTRL_OFS, 1'b1, {rnd[31:17], ~STANDBY_KEY[0], rnd[15:0]});
    rdchk(STANDBY_CTRL_OFS, 32'h0);
    bus(STANDBY_CTRL_OFS, 1'b1, {STANDBY_KEY, rnd[15:0]});
    rdchk(STANDBY_CTRL_OFS, {27'h0, rnd[4], 1'b0, rnd[2:0]});
    bus(RTC_MODE_CTRL_OFS, 1'b1, 32'h1);
    rdchk(RTC_MODE_CTRL_OFS, 32'h0);
    sub_osc_ready_flag <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(CLK_STATUS_OFS, 32'h1);
    bus(RTC_MODE_CTRL_OFS, 1'b1, 32'h1);
    rdchk(RTC_MODE_CTRL_OFS, 32'h1);
    bus(8'h18, 1'b1, rnd);
    rdchk(8'h18, 32'h0);
    // every wake cause in both modes, stop ones that must be ignored too
    for (int i = 0; i < 12; i++) begin
      rtc = (i < 6);
      c = i % 6;
      rnd = $random(seed);
      lvl = rnd[0];
      bus(SRAM_RETAIN_OFS, 1'b1, {31'h0, rnd[1]});
      enter();
      repeat (2) @(posedge clk);
      chk(32'(st), 32'({1'b0, rnd[1], lvl, rtc}));
      chk(32'(pins_gpio), 32'(!lvl));
      rdchk(SEQ_STATUS_OFS, rtc ? 32'h1 : 32'h2);
      other_reset_req <= rnd[5:2] | 4'h1;
      fire <= 1'b1;
      sel <= 3'(c);
      @(posedge clk);
      fire <= 1'b0;
      woke = wakes(rtc, c);
      wait_run();
      chk(32'(clk_en.cpu_en), 32'(woke));
      // watchdog-type request still raised: passes only once running
      @(posedge clk);
      chk(32'(sys_reset), 32'(woke));
      other_reset_req <= 4'h0;
      if (!woke) begin
        fire <= 1'b1;
        sel <= 3'h0;
        @(posedge clk);
        fire <= 1'b0;
        wait_run();
      end
      chk(32'(hcr_run_force), 32'h0);
      rdchk(WAKE_CAUSE_OFS, 32'h1 << (woke ? c : 0));
      rdchk(RTC_MODE_CTRL_OFS, {31'h0, rtc});
      rdchk(STANDBY_CTRL_OFS, {27'h0, lvl, 4'h6});
    end
    test_done();
  end
endmodule
bind dsbpc_ctrl dsbpc_ctrl_chk #(.REG_CYC(REG_CYC), .OSC_CYC(OSC_CYC)) u_chk (
  .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .external_reset_pin_n, .wake_up_pin, .lv_reset, .lv_irq, .sys_reset,
  .clk_en, .pwr_on, .dstb_rst, .hcr_run_force
);

// [dsbpc_ctrl.sv]
// deep standby power controller with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module dsbpc_ctrl
  import dsbpc_pkg::*;
#(
  parameter int REG_CYC = REG_WAIT_CYC,
  parameter int OSC_CYC = OSC_WAIT_CYC,
  parameter bit RETAIN_SUPPORTED = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sub_osc_ready_flag,
  input wire logic cpu_deep_sleep_bit,
  input wire logic cpu_sleep_req,
  input wire logic external_reset_pin_n,
  input wire logic wake_up_pin,
  input wire logic lv_reset,
  input wire logic lv_irq,
  input wire logic rtc_irq,
  input wire logic rcv_irq,
  input wire logic [3:0] other_reset_req,
  output logic sys_reset,
  output dsbpc_clk_t clk_en,
  output dsbpc_pwr_t pwr_on,
  output dsbpc_rst_t dstb_rst,
  output logic [PORT0_KEEP_BITS-1:0] port0_pfr_keep,
  output logic hcr_run_force,
  output logic pins_hiz,
  output logic pins_gpio
);
  dsbpc_state_t state_r;
  dsbpc_state_t state_nxt;
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] pin_raw;
  logic osc_rdy_s;
  logic ext_rst_s;
  logic wake_pin_s;
  logic rtc_mode_enable_r;
  logic deep_standby_select_r;
  logic [1:0] standby_type_field_r;
  logic standby_pin_level_r;
  logic sram_retain_r;
  logic [WAKE_W-1:0] wake_cause_r;
  logic [WAKE_W-1:0] wake_now;
  logic [WAKE_W-1:0] wake_clr;
  logic [WAKE_W-1:0] wake_allow;
  dsbpc_wake_t wake_in;
  logic in_standby;
  logic wake_hit;
  logic enter_req;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_expired;
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic ap_valid;
  logic wr_en;
  logic [31:0] rd_nxt;
  logic [31:0] hrdata_r;

  function automatic logic [31:0] word_of(input logic [WAKE_W-1:0] v);
    word_of = {{(32 - WAKE_W){1'b0}}, v};
  endfunction

  // pins from outside the clock domain: two flops before any use
  assign pin_raw = {sub_osc_ready_flag, ~external_reset_pin_n, wake_up_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
        end else begin
          sync1_r[g] <= pin_raw[g];
          sync2_r[g] <= sync1_r[g];
        end
      end
    end
  endgenerate

  assign osc_rdy_s = sync2_r[2];
  assign ext_rst_s = sync2_r[1];
  assign wake_pin_s = sync2_r[0];

  // AHB-Lite slave, zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign ap_valid = hsel && htrans[1] && hready;
  assign wr_en = dp_wr_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
    end else if (hready) begin
      dp_wr_r <= ap_valid && hwrite && hsize == 3'h2;
      dp_addr_r <= haddr[7:0];
    end
  end

  // read data is registered at the address phase so it stands in data phase
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (haddr[7:0])
      STANDBY_CTRL_OFS: begin
        rd_nxt[PIN_LEVEL_BIT] = standby_pin_level_r;
        rd_nxt[DS_SEL_BIT] = deep_standby_select_r;
        rd_nxt[STYPE_LSB +: 2] = standby_type_field_r;
      end
      RTC_MODE_CTRL_OFS: rd_nxt[0] = rtc_mode_enable_r;
      CLK_STATUS_OFS: rd_nxt[0] = osc_rdy_s;
      WAKE_CAUSE_OFS: rd_nxt = word_of(wake_cause_r);
      SEQ_STATUS_OFS: rd_nxt[2:0] = state_r;
      SRAM_RETAIN_OFS: rd_nxt[0] = sram_retain_r;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata_r <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      hrdata_r <= rd_nxt;
    end
  end

  // key reads back as zero because it is never stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      standby_pin_level_r <= 1'b0;
      deep_standby_select_r <= 1'b0;
      standby_type_field_r <= STYPE_RST;
    end else if (wr_en && dp_addr_r == STANDBY_CTRL_OFS &&
                 hwdata[KEY_LSB +: 16] == STANDBY_KEY) begin
      standby_pin_level_r <= hwdata[PIN_LEVEL_BIT];
      deep_standby_select_r <= hwdata[DS_SEL_BIT];
      standby_type_field_r <= hwdata[STYPE_LSB +: 2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtc_mode_enable_r <= 1'b0;
    end else if (wr_en && dp_addr_r == RTC_MODE_CTRL_OFS) begin
      if (!hwdata[0] || osc_rdy_s) begin
        rtc_mode_enable_r <= hwdata[0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sram_retain_r <= 1'b0;
    end else if (wr_en && dp_addr_r == SRAM_RETAIN_OFS) begin
      sram_retain_r <= hwdata[0] & RETAIN_SUPPORTED;
    end
  end

  // wake causes; rtc-only causes are masked in stop mode
  assign wake_in = '{ext_rst: ext_rst_s, lv_rst: lv_reset,
                     lv_irq: lv_irq, rtc_irq: rtc_irq,
                     rcv_irq: rcv_irq, wake_pin: wake_pin_s};
  assign wake_allow = (state_r == DSB_STOP) ? 6'h39 : 6'h3F;
  assign in_standby = state_r == DSB_RTC || state_r == DSB_STOP;
  assign wake_now = in_standby ? (wake_in & wake_allow) : '0;
  // debugger and watchdog events are not wake inputs at all
  assign wake_hit = |wake_now;
  assign wake_clr = (wr_en && dp_addr_r == WAKE_CAUSE_OFS) ?
                    hwdata[WAKE_W-1:0] : '0;

  // write one clears; a new cause in the same cycle wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_cause_r <= '0;
    end else begin
      wake_cause_r <= (wake_cause_r & ~wake_clr) | wake_now;
    end
  end

  // watchdog-type resets only pass while running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_reset <= 1'b0;
    end else begin
      sys_reset <= state_r == DSB_RUN && |other_reset_req;
    end
  end

  // entry needs deep standby select, stop type and a deep sleep request
  assign enter_req = cpu_sleep_req && cpu_deep_sleep_bit &&
                     deep_standby_select_r &&
                     standby_type_field_r == STYPE_STOP;

  always_comb begin
    state_nxt = state_r;
    tmr_load = 1'b0;
    tmr_val = TMR_W'(REG_CYC);
    case (state_r)
      DSB_RUN: begin
        if (enter_req) begin
          state_nxt = rtc_mode_enable_r ? DSB_RTC : DSB_STOP;
        end
      end
      DSB_RTC, DSB_STOP: begin
        if (wake_hit) begin
          state_nxt = DSB_REG_WAIT;
          tmr_load = 1'b1;
        end
      end
      DSB_REG_WAIT: begin
        if (tmr_expired) begin
          state_nxt = DSB_OSC_WAIT;
          tmr_load = 1'b1;
          tmr_val = TMR_W'(OSC_CYC);
        end
      end
      DSB_OSC_WAIT: begin
        if (tmr_expired) begin
          state_nxt = DSB_RUN;
        end
      end
      default: state_nxt = DSB_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= DSB_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one timer serves both waits; they never overlap
  dsbpc_wait_timer #(.W(TMR_W)) u_timer (
    .clk(clk),
    .reset(reset),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_expired)
  );

  // gate and power outputs are registered to avoid glitches
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clk_en <= '1;
    end else begin
      clk_en.hcr_en <= state_nxt == DSB_RUN ||
                       state_nxt == DSB_OSC_WAIT;
      clk_en.lcr_en <= state_nxt == DSB_RUN ||
                       state_nxt == DSB_OSC_WAIT;
      clk_en.main_en <= state_nxt == DSB_RUN;
      clk_en.pll_en <= state_nxt == DSB_RUN;
      clk_en.usbpll_en <= state_nxt == DSB_RUN;
      clk_en.sub_en <= state_nxt != DSB_STOP;
      clk_en.cpu_en <= state_nxt == DSB_RUN;
      clk_en.ahb_en <= state_nxt == DSB_RUN;
      clk_en.apb_en <= {3{state_nxt == DSB_RUN}};
    end
  end

  // flash keeps its contents unpowered; always-on blocks have no switch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwr_on <= '1;
    end else begin
      pwr_on.cpu <= !(state_nxt inside {DSB_RTC, DSB_STOP});
      pwr_on.flash <= !(state_nxt inside {DSB_RTC, DSB_STOP});
      pwr_on.periph <= !(state_nxt inside {DSB_RTC, DSB_STOP});
      pwr_on.debug <= !(state_nxt inside {DSB_RTC, DSB_STOP});
      pwr_on.sram <= !(state_nxt inside {DSB_RTC, DSB_STOP}) ||
                     sram_retain_r;
    end
  end

  // transition reset held from entry until both waits expire;
  // this block's own registers see only the power-on reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dstb_rst <= '0;
      hcr_run_force <= 1'b0;
    end else begin
      dstb_rst <= {4{state_nxt != DSB_RUN}};
      hcr_run_force <= state_nxt != DSB_RUN;
    end
  end

  // gpio honours this mask when clearing its function registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port0_pfr_keep <= '0;
    end else begin
      port0_pfr_keep <= '1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins_hiz <= 1'b0;
      pins_gpio <= 1'b0;
    end else begin
      pins_hiz <= in_standby && standby_pin_level_r;
      pins_gpio <= in_standby && !standby_pin_level_r;
    end
  end
endmodule

// [dsbpc_ctrl_properties.sv]
// concurrent checks on the deep standby controller ports
`timescale 1ns/10ps
module dsbpc_ctrl_chk
  import dsbpc_pkg::*;
#(
  parameter int REG_CYC = REG_WAIT_CYC,
  parameter int OSC_CYC = OSC_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic external_reset_pin_n,
  input wire logic wake_up_pin,
  input wire logic lv_reset,
  input wire logic lv_irq,
  input wire logic sys_reset,
  input wire dsbpc_clk_t clk_en,
  input wire dsbpc_pwr_t pwr_on,
  input wire dsbpc_rst_t dstb_rst,
  input wire logic hcr_run_force
);
  logic [2:0] quiet_r;
  int reg_cnt_r;
  int osc_cnt_r;
  logic asleep;
  assign asleep = !pwr_on.cpu;
  // pins cross two sync flops, so keep three edges of history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      quiet_r <= 3'h0;
      reg_cnt_r <= 0;
      osc_cnt_r <= 0;
    end else begin
      quiet_r <= {quiet_r[1:0], external_reset_pin_n & ~wake_up_pin};
      reg_cnt_r <= (pwr_on.cpu && !clk_en.hcr_en) ? reg_cnt_r + 1 : 0;
      osc_cnt_r <= (clk_en.hcr_en && !clk_en.cpu_en) ? osc_cnt_r + 1 : 0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_key_read_zero: assert property (hsel && htrans[1] && hready &&
    !hwrite && haddr == 32'h0 |=> hrdata[31:16] == 16'h0)
    else $error("key field read back nonzero");
  a_bus_clk_off: assert property (hcr_run_force |->
    !clk_en.cpu_en && !clk_en.ahb_en && clk_en.apb_en == 3'h0)
    else $error("core or bus clock running outside run");
  a_osc_stopped: assert property (asleep |-> !(clk_en.hcr_en ||
    clk_en.main_en || clk_en.pll_en || clk_en.lcr_en || clk_en.usbpll_en))
    else $error("oscillator left running in standby");
  a_domains_off: assert property (asleep |->
    !pwr_on.flash && !pwr_on.periph && !pwr_on.debug)
    else $error("domain powered in standby");
  a_reset_held: assert property (hcr_run_force |->
    dstb_rst.core && dstb_rst.cpu_interrupt_controller && dstb_rst.periph)
    else $error("transition reset dropped early");
  a_reg_wait_len: assert property ($rose(clk_en.hcr_en) |->
    reg_cnt_r == REG_CYC + 1 && clk_en.lcr_en && !clk_en.cpu_en)
    else $error("regulator wait length wrong");
  a_osc_wait_len: assert property ($rose(clk_en.cpu_en) |->
    osc_cnt_r == OSC_CYC + 1 && dstb_rst == 4'h0 && !hcr_run_force)
    else $error("oscillator wait length wrong");
  a_no_wdt_reset: assert property (hcr_run_force && $past(hcr_run_force)
    |-> !sys_reset)
    else $error("system reset issued in standby");
  a_stop_ignores: assert property (asleep && !clk_en.sub_en &&
    &quiet_r && !lv_reset && !lv_irq |=> asleep)
    else $error("stop mode left without valid cause");
  c_rtc_mode: cover property (asleep && clk_en.sub_en);
  c_stop_mode: cover property (asleep && !clk_en.sub_en);
  c_back_to_run: cover property ($rose(clk_en.cpu_en));
endmodule

// [dsbpc_pkg.sv]
// shared constants and types for the deep standby power controller
package dsbpc_pkg;
  localparam logic [7:0] STANDBY_CTRL_OFS = 8'h00;
  localparam logic [7:0] RTC_MODE_CTRL_OFS = 8'h04;
  localparam logic [7:0] CLK_STATUS_OFS = 8'h08;
  localparam logic [7:0] WAKE_CAUSE_OFS = 8'h0C;
  localparam logic [7:0] SEQ_STATUS_OFS = 8'h10;
  localparam logic [7:0] SRAM_RETAIN_OFS = 8'h14;
  localparam int KEY_LSB = 16;
  localparam int PIN_LEVEL_BIT = 4;
  localparam int DS_SEL_BIT = 2;
  localparam int STYPE_LSB = 0;
  localparam logic [15:0] STANDBY_KEY = 16'h1ACC;
  localparam logic [1:0] STYPE_STOP = 2'h2;
  localparam logic [1:0] STYPE_RST = 2'h0;
  localparam int WAKE_W = 6;
  localparam int PORT0_KEEP_BITS = 5;
  localparam int CLK_MHZ = 20;
  localparam int REG_WAIT_US = 300;
  localparam int OSC_WAIT_US = 50;
  localparam int REG_WAIT_CYC = REG_WAIT_US * CLK_MHZ;
  localparam int OSC_WAIT_CYC = OSC_WAIT_US * CLK_MHZ;
  localparam int TMR_W = 16;
  typedef enum logic [2:0] {
    DSB_RUN, DSB_RTC, DSB_STOP, DSB_REG_WAIT, DSB_OSC_WAIT
  } dsbpc_state_t;
  typedef struct packed {
    logic hcr_en;
    logic main_en;
    logic pll_en;
    logic lcr_en;
    logic sub_en;
    logic usbpll_en;
    logic cpu_en;
    logic ahb_en;
    logic [2:0] apb_en;
  } dsbpc_clk_t;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic sram;
    logic periph;
    logic debug;
  } dsbpc_pwr_t;
  typedef struct packed {
    logic core;
    logic cpu_interrupt_controller;
    logic periph;
    logic gpio_pfr;
  } dsbpc_rst_t;
  typedef struct packed {
    logic ext_rst;
    logic lv_rst;
    logic lv_irq;
    logic rtc_irq;
    logic rcv_irq;
    logic wake_pin;
  } dsbpc_wake_t;
endpackage

// [dsbpc_wait_timer.sv]
// down counter for the stabilization waits
`timescale 1ns/10ps
module dsbpc_wait_timer
  import dsbpc_pkg::*;
#(
  parameter int W = TMR_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expired
);
  logic [W-1:0] cnt_r;
  logic running_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (running_r && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      running_r <= 1'b0;
    end else if (load) begin
      running_r <= 1'b1;
    end
  end

  assign expired = running_r && cnt_r == '0;
endmodule

// [dsbpc_wake_model.sv]
// always-on wake sources: pulses one chosen wake input
`timescale 1ns/10ps
module dsbpc_wake_model (
  input wire logic clk,
  input wire logic fire,
  input wire logic [2:0] sel,
  output logic external_reset_pin_n,
  output logic wake_up_pin,
  output logic lv_reset,
  output logic lv_irq,
  output logic rtc_irq,
  output logic rcv_irq
);
  logic [5:0] act_r = 6'h00;
  logic [2:0] left_r = 3'h0;
  // held several cycles so the pin synchronizers catch it
  always @(posedge clk) begin
    if (fire) begin
      act_r <= 6'h01 << sel;
      left_r <= 3'h4;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end else begin
      act_r <= 6'h00;
    end
  end
  assign external_reset_pin_n = !act_r[5];
  assign lv_reset = act_r[4];
  assign lv_irq = act_r[3];
  assign rtc_irq = act_r[2];
  assign rcv_irq = act_r[1];
  assign wake_up_pin = act_r[0];
endmodule
